// file: src/bctc_pkg.sv
// constants, state type and behaviour summary for bus cycle termination
// How it works
// - bus monitor raises bus error on timeout
// - halt with ack: finish, stop, resume later
// - bus error without halt: end, take exception
// - bus error with halt: end, rerun later
// - sample terminations at state N and N+2
// - exception only when bus error without halt
// - bus error latched at cycle close, deferred
// - bus error: no data, prefetch loads ones
// - handler first instruction clears error latch
// - double fault in three listed cases
// - many errors in one instruction, one exception
// - double fault stops, drives halt, grants bus
// - errors after handler start stay ordinary
// - retry: strobes off, wait, rerun same cycle
// - retries repeat without any limit
// - retry with bus request: grant first, rerun
// - locked cycles retried singly, lock held
// - halted: strobes off, data floats, address held
// - no bus grant decided while lock is active; ST_GRANT then ignores lock
package bctc_pkg;
   // system clock period and bus monitor time-out
   localparam int CLK_PERIOD_NS  = 10;
   localparam int MON_TIMEOUT_NS = 640;
   localparam int MON_CYCLES     = (MON_TIMEOUT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   // bus widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int FC_W   = 3;
   localparam int SIZ_W  = 2;
   // value latched on an errored prefetch (precharged bus)
   localparam logic [DATA_W-1:0] PREFETCH_ONES = 16'hFFFF;
   // bit positions in the synchronised pin vector
   localparam int SY_BR   = 0;
   localparam int SY_HALT = 1;
   localparam int SY_BUS_ERROR_IN = 2;
   localparam int SY_AUTOVECTOR_ACK = 3;
   localparam int SY_ACK0 = 4;
   localparam int SY_ACK1 = 5;
   localparam int SY_DATA = 6;
   localparam int SY_W    = SY_DATA + DATA_W;
   // bus controller states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_SAMP,
      ST_EVAL,
      ST_HALT,
      ST_RETRY,
      ST_GRANT,
      ST_DFAULT
   } bctc_state_e;
endpackage : bctc_pkg

// file: src/bctc_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bctc_sync #(
   parameter int W = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   // first stage is read only by the second stage
   logic [W-1:0] meta_reg;

   // both stages freeze with the clock enable; reset to all ones
   // because every control pin is active low
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_reg <= {W{1'b1}};
         o_sync   <= {W{1'b1}};
      end else if (i_ce) begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end
endmodule : bctc_sync
`default_nettype wire

// file: src/bctc_ctrl.sv
// bus cycle termination and bus exception controller
`timescale 1ns/1ps
`default_nettype none
module bctc_ctrl #(
   parameter logic [15:0] P_MON_CYCLES = 16'(bctc_pkg::MON_CYCLES)
) (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rstn,
   input  wire logic                        i_ce,
   // core side
   input  wire logic                        i_cyc_start,
   input  wire logic [bctc_pkg::ADDR_W-1:0] i_cyc_addr,
   input  wire logic [bctc_pkg::FC_W-1:0]   i_cyc_fc,
   input  wire logic [bctc_pkg::SIZ_W-1:0]  i_cyc_siz,
   input  wire logic                        i_cyc_rd,
   input  wire logic [bctc_pkg::DATA_W-1:0] i_cyc_wdata,
   input  wire logic                        i_cyc_prefetch,
   input  wire logic                        i_cyc_locked,
   input  wire logic                        i_monitor_en,
   input  wire logic                        i_insn_end,
   input  wire logic                        i_insn_first,
   input  wire logic                        i_handler_first,
   input  wire logic                        i_rte_frame,
   // pins; strobes, acks, error, halt, request, lock and grant are active low
   input  wire logic [1:0]                  i_data_size_ack_n,
   input  wire logic                        i_autovector_ack_n,
   input  wire logic                        i_bus_error_in_n,
   input  wire logic                        i_halt_n,
   input  wire logic                        i_bus_request_n,
   input  wire logic [bctc_pkg::DATA_W-1:0] i_data_in,
   output logic                             o_address_strobe_n,
   output logic                             o_data_strobe_n,
   output logic      [bctc_pkg::ADDR_W-1:0] o_addr,
   output logic      [bctc_pkg::FC_W-1:0]   o_fc,
   output logic      [bctc_pkg::SIZ_W-1:0]  o_siz,
   output logic                             o_rw,
   output logic      [bctc_pkg::DATA_W-1:0] o_data_out,
   output logic                             o_data_oe,
   output logic                             o_locked_rmw_n,
   output logic                             o_bus_grant_n,
   output logic                             o_halt_o,
   output logic                             o_halt_oe,
   // status back to the core
   output logic                             o_cyc_busy,
   output logic                             o_cyc_done,
   output logic                             o_cyc_bus_error_in,
   output logic      [bctc_pkg::DATA_W-1:0] o_cyc_rdata,
   output logic                             o_bus_error_in_latched,
   output logic                             o_bus_error_in_exc,
   output logic                             o_double_fault
);
   // synchronised pin vector and its decoded, active high view
   logic [bctc_pkg::SY_W-1:0] sy;
   logic ack_s;                   // size ack or autovector ack
   logic bus_error_in_pin_s;              // external bus error
   logic halt_s;                  // external halt
   logic br_s;                    // external bus request
   logic bus_error_in_any;                // external or monitor bus error

   // controller state and per-cycle bookkeeping
   bctc_pkg::bctc_state_e state_reg;
   logic [15:0] mon_cnt_reg;      // cycles spent waiting for an end
   logic        mon_bus_error_in_reg;     // monitor raised bus error
   logic        rerun_reg;        // a rerun is owed after the grant
   logic        exc_taken_reg;    // exception started, handler not yet
   logic        after_reset_reg;  // no instruction run since reset

   // outcome decode at the second sample
   logic term_retry;
   logic term_bus_error_in;
   logic term_halt;
   logic dfault_now;

   // all pins pass two flops; data rides along with the controls so
   // that it lines up with the acknowledge it belongs to
   bctc_sync #(
      .W (bctc_pkg::SY_W)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_ce       (i_ce),
      .i_async    ({i_data_in, i_data_size_ack_n, i_autovector_ack_n,
                    i_bus_error_in_n, i_halt_n, i_bus_request_n}),
      .o_sync     (sy)
   );

   // a normal end needs either size ack line or the autovector ack
   assign ack_s      = !sy[bctc_pkg::SY_ACK0] || !sy[bctc_pkg::SY_ACK1]
                       || !sy[bctc_pkg::SY_AUTOVECTOR_ACK];
   assign bus_error_in_pin_s = !sy[bctc_pkg::SY_BUS_ERROR_IN];
   assign halt_s     = !sy[bctc_pkg::SY_HALT];
   assign br_s       = !sy[bctc_pkg::SY_BR];
   assign bus_error_in_any   = bus_error_in_pin_s || mon_bus_error_in_reg;

   // classification at N+2: error with halt reruns, error alone ends
   // with an exception, halt alone finishes and then stops
   assign term_retry = (state_reg == bctc_pkg::ST_EVAL) && bus_error_in_any
                       && halt_s;
   assign term_bus_error_in  = (state_reg == bctc_pkg::ST_EVAL) && bus_error_in_any
                       && !halt_s;
   assign term_halt  = (state_reg == bctc_pkg::ST_EVAL) && !bus_error_in_any
                       && halt_s;
   // an error before the handler starts, before the first instruction
   // after reset, or while restoring an error frame is fatal
   assign dfault_now = term_bus_error_in && (exc_taken_reg || after_reset_reg
                       || i_rte_frame);

   // a bus request may be granted only when no lock is held
   function automatic logic grant_ok(input logic br, input logic lk);
      grant_ok = br && !lk;
   endfunction : grant_ok

   // main bus controller
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= bctc_pkg::ST_IDLE;
         rerun_reg <= 1'b0;
      end else if (i_ce) begin
         case (state_reg)
            bctc_pkg::ST_IDLE: begin
               // arbitration first, so an owner gets the bus between
               // cycles; a start arriving then is ignored
               if (grant_ok(br_s, !o_locked_rmw_n)) begin
                  state_reg <= bctc_pkg::ST_GRANT;
               end else if (i_cyc_start) begin
                  state_reg <= bctc_pkg::ST_ADDR;
               end
            end
            // strobes are out; the first even state follows
            bctc_pkg::ST_ADDR: state_reg <= bctc_pkg::ST_SAMP;
            bctc_pkg::ST_SAMP: begin
               // sample at state N: any acknowledge or error starts
               // the two-state classification window
               if (ack_s || bus_error_in_any) begin
                  state_reg <= bctc_pkg::ST_EVAL;
               end
            end
            bctc_pkg::ST_EVAL: begin
               if (term_retry) begin
                  // with a bus request the bus goes out first
                  if (grant_ok(br_s, !o_locked_rmw_n)) begin
                     state_reg <= bctc_pkg::ST_GRANT;
                     rerun_reg <= 1'b1;
                  end else begin
                     state_reg <= bctc_pkg::ST_RETRY;
                  end
               end else if (dfault_now) begin
                  state_reg <= bctc_pkg::ST_DFAULT;
               end else if (term_halt) begin
                  state_reg <= bctc_pkg::ST_HALT;
               end else begin
                  state_reg <= bctc_pkg::ST_IDLE;
               end
            end
            bctc_pkg::ST_HALT: begin
               // arbitration is still honoured while halted
               if (grant_ok(br_s, !o_locked_rmw_n)) begin
                  state_reg <= bctc_pkg::ST_GRANT;
               end else if (!halt_s) begin
                  state_reg <= bctc_pkg::ST_IDLE;
               end
            end
            bctc_pkg::ST_RETRY: begin
               // rerun once both error and halt are gone; no limit
               // on how often this loop is taken
               if (!bus_error_in_pin_s && !halt_s) begin
                  state_reg <= bctc_pkg::ST_ADDR;
               end
            end
            bctc_pkg::ST_GRANT: begin
               if (!br_s) begin
                  state_reg <= rerun_reg ? bctc_pkg::ST_RETRY
                                         : bctc_pkg::ST_IDLE;
                  rerun_reg <= 1'b0;
               end
            end
            // only reset leaves the double fault state
            bctc_pkg::ST_DFAULT: state_reg <= bctc_pkg::ST_DFAULT;
            default: state_reg <= bctc_pkg::ST_IDLE;
         endcase
      end
   end

   // bus monitor: counts the wait for an end and, on time-out, stands
   // in for an external bus error until the next cycle starts
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mon_cnt_reg  <= 16'h0000;
         mon_bus_error_in_reg <= 1'b0;
      end else if (i_ce) begin
         if (state_reg == bctc_pkg::ST_ADDR) begin
            mon_cnt_reg  <= 16'h0000;
            mon_bus_error_in_reg <= 1'b0;
         end else if (state_reg == bctc_pkg::ST_SAMP && i_monitor_en
                      && !mon_bus_error_in_reg) begin
            mon_cnt_reg <= mon_cnt_reg + 16'h0001;
            if (mon_cnt_reg == P_MON_CYCLES - 16'h0001) begin
               mon_bus_error_in_reg <= 1'b1;
            end
         end
      end
   end

   // address, attributes and write data: loaded only at a new start,
   // so a halt or a rerun sees exactly the previous cycle
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_addr     <= '0;
         o_fc       <= '0;
         o_siz      <= '0;
         o_rw       <= 1'b1;
         o_data_out <= '0;
      end else if (i_ce && state_reg == bctc_pkg::ST_IDLE && i_cyc_start
                   && !grant_ok(br_s, !o_locked_rmw_n)) begin
         o_addr     <= i_cyc_addr;
         o_fc       <= i_cyc_fc;
         o_siz      <= i_cyc_siz;
         o_rw       <= i_cyc_rd;
         o_data_out <= i_cyc_wdata;
      end
   end

   // strobes and data drive: on from the address state until the
   // second sample, off in every waiting state
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_address_strobe_n <= 1'b1;
         o_data_strobe_n    <= 1'b1;
         o_data_oe          <= 1'b0;
      end else if (i_ce) begin
         if ((state_reg == bctc_pkg::ST_IDLE && i_cyc_start
              && !grant_ok(br_s, !o_locked_rmw_n))
             || (state_reg == bctc_pkg::ST_RETRY && !bus_error_in_pin_s
                 && !halt_s)) begin
            o_address_strobe_n <= 1'b0;
            o_data_strobe_n    <= 1'b0;
            o_data_oe          <= (state_reg == bctc_pkg::ST_IDLE)
                                  ? !i_cyc_rd : !o_rw;
         end else if (state_reg == bctc_pkg::ST_EVAL) begin
            // every outcome ends the cycle; data bus floats
            o_address_strobe_n <= 1'b1;
            o_data_strobe_n    <= 1'b1;
            o_data_oe          <= 1'b0;
         end
      end
   end

   // lock follows the core but is never dropped in a rerun window
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_locked_rmw_n <= 1'b1;
      end else if (i_ce) begin
         if (i_cyc_locked) begin
            o_locked_rmw_n <= 1'b0;
         end else if (state_reg == bctc_pkg::ST_IDLE) begin
            o_locked_rmw_n <= 1'b1;
         end
      end
   end

   // bus grant, also while stopped on a double fault; the lock keeps
   // the grant back so a locked sequence is never split
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_bus_grant_n <= 1'b1;
      end else if (i_ce) begin
         if (state_reg == bctc_pkg::ST_DFAULT) begin
            o_bus_grant_n <= !grant_ok(br_s, !o_locked_rmw_n);
         end else if (state_reg == bctc_pkg::ST_GRANT) begin
            o_bus_grant_n <= !br_s;
         end else begin
            o_bus_grant_n <= 1'b1;
         end
      end
   end

   // completion toward the core; a retry reports nothing until the
   // rerun itself ends
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cyc_done  <= 1'b0;
         o_cyc_bus_error_in  <= 1'b0;
         o_cyc_rdata <= '0;
         o_cyc_busy  <= 1'b0;
      end else if (i_ce) begin
         o_cyc_done <= (state_reg == bctc_pkg::ST_EVAL) && !term_retry;
         o_cyc_bus_error_in <= term_bus_error_in;
         o_cyc_busy <= !(state_reg == bctc_pkg::ST_IDLE && !i_cyc_start)
                       || grant_ok(br_s, !o_locked_rmw_n);
         if (term_bus_error_in) begin
            // no capture on an error; a prefetch gets the precharge
            if (i_cyc_prefetch) begin
               o_cyc_rdata <= bctc_pkg::PREFETCH_ONES;
            end
         end else if (state_reg == bctc_pkg::ST_EVAL && !term_retry
                      && o_rw) begin
            o_cyc_rdata <= sy[bctc_pkg::SY_DATA +: bctc_pkg::DATA_W];
         end
      end
   end

   // error latch and exception bookkeeping; a new error in the same
   // cycle as the handler's first instruction wins over the clear
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_bus_error_in_latched  <= 1'b0;
         o_bus_error_in_exc      <= 1'b0;
         exc_taken_reg   <= 1'b0;
         after_reset_reg <= 1'b1;
      end else if (i_ce) begin
         if (term_bus_error_in) begin
            o_bus_error_in_latched <= 1'b1;
         end else if (i_handler_first) begin
            o_bus_error_in_latched <= 1'b0;
         end
         // one exception per instruction boundary, however many
         // errors the instruction collected
         o_bus_error_in_exc <= i_insn_end && o_bus_error_in_latched
                       && !exc_taken_reg;
         if (i_insn_end && o_bus_error_in_latched && !exc_taken_reg) begin
            exc_taken_reg <= 1'b1;
         end else if (i_handler_first) begin
            exc_taken_reg <= 1'b0;
         end
         if (i_insn_first) begin
            after_reset_reg <= 1'b0;
         end
      end
   end

   // double fault: stop and pull the halt line low until reset
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_double_fault <= 1'b0;
         o_halt_oe      <= 1'b0;
         o_halt_o       <= 1'b0;
      end else if (i_ce) begin
         o_halt_o <= 1'b0;
         if (dfault_now) begin
            o_double_fault <= 1'b1;
            o_halt_oe      <= 1'b1;
         end
      end
   end

   // checks; a frozen clock enable suspends them
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn || !i_ce);

   sequence s_eval_ok;
      state_reg == bctc_pkg::ST_EVAL && !bus_error_in_any && !halt_s;
   endsequence
   sequence s_release;
      state_reg == bctc_pkg::ST_RETRY && !bus_error_in_pin_s && !halt_s;
   endsequence

   property p_norm_end;
      s_eval_ok |=> o_cyc_done && !o_cyc_bus_error_in && o_address_strobe_n;
   endproperty
   a_norm_end: assert property (p_norm_end)
      else $error("normal end not reported");

   property p_bus_error_in_latch;
      term_bus_error_in |=> o_cyc_done && o_cyc_bus_error_in && o_bus_error_in_latched;
   endproperty
   a_bus_error_in_latch: assert property (p_bus_error_in_latch)
      else $error("bus error end not latched");

   property p_prefetch;
      term_bus_error_in && i_cyc_prefetch |=>
         o_cyc_rdata == bctc_pkg::PREFETCH_ONES;
   endproperty
   a_prefetch: assert property (p_prefetch)
      else $error("errored prefetch did not load ones");

   property p_retry_quiet;
      term_retry |=> !o_cyc_done ##0 o_address_strobe_n [*2];
   endproperty
   a_retry_quiet: assert property (p_retry_quiet)
      else $error("retry left strobes on or reported done");

   property p_rerun_same;
      s_release |=> !o_address_strobe_n && $stable(o_addr)
                    && $stable(o_fc) && $stable(o_data_out);
   endproperty
   a_rerun_same: assert property (p_rerun_same)
      else $error("rerun did not repeat the cycle");

   property p_halt_hold;
      state_reg == bctc_pkg::ST_HALT |-> o_address_strobe_n
         && o_data_strobe_n && !o_data_oe && $stable(o_addr);
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("halted bus not idle");

   property p_dfault;
      dfault_now |=> o_halt_oe && !o_halt_o
         && state_reg == bctc_pkg::ST_DFAULT;
   endproperty
   a_dfault: assert property (p_dfault)
      else $error("double fault did not stop");

   property p_no_grant_lock;
      !o_locked_rmw_n && $past(!o_locked_rmw_n) |-> o_bus_grant_n;
   endproperty
   a_no_grant_lock: assert property (p_no_grant_lock)
      else $error("grant while locked");

   property p_one_exc;
      o_bus_error_in_exc |=> !o_bus_error_in_exc;
   endproperty
   a_one_exc: assert property (p_one_exc)
      else $error("two exceptions back to back");

   property p_monitor;
      state_reg == bctc_pkg::ST_SAMP && i_monitor_en && !ack_s
         && !bus_error_in_pin_s && mon_cnt_reg == P_MON_CYCLES - 16'h0001
         |=> mon_bus_error_in_reg ##1 state_reg == bctc_pkg::ST_EVAL;
   endproperty
   a_monitor: assert property (p_monitor)
      else $error("monitor time-out missed");
endmodule : bctc_ctrl
`default_nettype wire

// file: tb/bctc_far_model.sv
// far side model: size ack, bus error and halt responder
`timescale 1ns/1ps
`default_nettype none
module bctc_far_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_as_n,
   input  wire logic [2:0]  i_mode,
   input  wire logic        i_hold,
   output logic             o_ack_n,
   output logic             o_bus_error_in_n,
   output logic             o_halt_n,
   output logic      [15:0] o_data
);
   // modes: 0 ack, 1 bus error, 2 halt and ack, 3 retry, 4 no answer
   initial begin
      {o_ack_n, o_bus_error_in_n, o_halt_n} = 3'h7;
      o_data = 16'h0000;
   end
   // lines move only just after rising edges
   always @(posedge i_core_clk) begin
      #1;
      // acks drop as soon as the strobe is gone
      o_ack_n  <= !(!i_as_n && (i_mode == 3'h0 || i_mode == 3'h2));
      // error released with the strobe unless retry is held
      o_bus_error_in_n <= !((!i_as_n && i_mode[0]) || (i_hold && i_mode == 3'h3));
      o_halt_n <= !(i_mode[1] && i_hold);
      // idle data bus toggles so a stale word never looks valid
      o_data   <= i_as_n ? ~o_data : 16'ha5c3;
   end
endmodule : bctc_far_model
`default_nettype wire

// file: tb/bus_cycle_termination_ctrl_bench.sv
// self-checking bench for the bus cycle termination controller
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_termination_ctrl_bench;
   typedef struct packed {
      logic [2:0]  mode;
      logic        rd, pf, bus_error_in;
      logic [15:0] data;
   } bctc_row_s;
   logic        clk, rstn, start, rd, pf, ie, ifirst, hf, br_n, hold;
   logic        as_n, ds_n, busy, done, cb, lat, exc, df, hoe, gnt_n;
   logic        ack_n, be_n, h_n, e;
   logic        ce, exception_return;          // enable and frame restore, bench driven
   logic [2:0]  mode;
   logic [23:0] addr, oaddr;
   logic [15:0] rdat, dq;
   int          compares, n_mismatch, cyc, k;
   bctc_row_s   rows [4];
   bctc_ctrl #(.P_MON_CYCLES(16'h0004)) bctc_ctrl_inst (
      .i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cyc_start(start),
      .i_cyc_addr(addr), .i_cyc_fc(3'h5), .i_cyc_siz(2'h2), .i_cyc_rd(rd),
      .i_cyc_wdata(addr[15:0]), .i_cyc_prefetch(pf), .i_cyc_locked(1'b0),
      .i_monitor_en(rstn), .i_insn_end(ie), .i_insn_first(ifirst),
      .i_handler_first(hf), .i_rte_frame(exception_return),
      .i_data_size_ack_n({ack_n, ack_n}), .i_autovector_ack_n(1'b1),
      .i_bus_error_in_n(be_n), .i_halt_n(h_n), .i_bus_request_n(br_n),
      .i_data_in(dq), .o_address_strobe_n(as_n), .o_data_strobe_n(ds_n),
      .o_addr(oaddr), .o_fc(), .o_siz(), .o_rw(), .o_data_out(),
      .o_data_oe(), .o_locked_rmw_n(), .o_bus_grant_n(gnt_n), .o_halt_o(),
      .o_halt_oe(hoe), .o_cyc_busy(busy), .o_cyc_done(done), .o_cyc_bus_error_in(cb),
      .o_cyc_rdata(rdat), .o_bus_error_in_latched(lat), .o_bus_error_in_exc(exc),
      .o_double_fault(df));
   bctc_far_model bctc_far_model_inst (.i_core_clk(clk), .i_as_n(as_n),
      .i_mode(mode), .i_hold(hold), .o_ack_n(ack_n), .o_bus_error_in_n(be_n),
      .o_halt_n(h_n), .o_data(dq));
   task automatic end_sim;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic check(input string what, input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // inputs move 2 ns after the edge, after the model's own update
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   // bounded wait for a cycle end, only one start in flight
   task automatic wait_done;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         tick(1);
         k++;
      end
      check("done", 24'(done), 24'h1);
   endtask : wait_done
   task automatic run(input logic r, p, input logic [23:0] a);
      rd = r;
      pf = p;
      addr = a;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      wait_done();
   endtask : run
   task automatic pulse_ie;
      e = 1'b0;
      ie = 1'b1;
      tick(1);
      ie = 1'b0;
      repeat (3) begin
         e |= exc;
         tick(1);
      end
   endtask : pulse_ie
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard, far above the fewer than two hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      {rstn, start, rd, pf, ie, ifirst, hf, hold} = 8'h00;
      {br_n, mode, addr} = {1'b1, 3'h0, 24'h00_0000};
      {ce, exception_return} = 2'b10;
      rows[0] = {3'h0, 1'b1, 1'b0, 1'b0, 16'ha5c3};
      rows[1] = {3'h0, 1'b0, 1'b0, 1'b0, 16'h0000};
      rows[2] = {3'h1, 1'b1, 1'b1, 1'b1, 16'hffff};
      rows[3] = {3'h4, 1'b1, 1'b1, 1'b1, 16'hffff};
      tick(2);
      rstn = 1'b1;
      check("reset", 24'({as_n, ds_n, gnt_n, hoe, df}), 24'h1c);
      ifirst = 1'b1;
      tick(1);
      ifirst = 1'b0;
      // plain ends, bus error, monitor time-out, each with exception flow
      for (int i = 0; i < 4; i++) begin
         mode = rows[i].mode;
         run(rows[i].rd, rows[i].pf, 24'(i));
         check("bus_error_in", 24'(cb), 24'(rows[i].bus_error_in));
         if (rows[i].rd) check("rdata", 24'(rdat), 24'(rows[i].data));
         tick(2);
         check("latch", 24'(lat), 24'(rows[i].bus_error_in));
         pulse_ie();
         check("exc", 24'(e), 24'(rows[i].bus_error_in));
         hf = 1'b1;
         tick(1);
         hf = 1'b0;
         tick(1);
         check("latch clr", 24'(lat), 24'h0);
      end
      // halt with ack: finish, stop, resume
      {mode, hold} = {3'h2, 1'b1};
      run(1'b1, 1'b0, 24'h55);
      check("halt data", 24'(rdat), 24'h00_a5c3);
      tick(4);
      check("halted", 24'({busy, as_n, ds_n}), 24'h7);
      check("held addr", oaddr, 24'h55);
      hold = 1'b0;
      tick(8);
      check("resumed", 24'(busy), 24'h0);
      // retry with a bus request: strobes off, grant, then rerun
      {mode, hold} = {3'h3, 1'b1};
      addr = 24'h77;
      // request rises with the start so it is seen at the classification
      {start, br_n} = 2'b10;
      tick(1);
      start = 1'b0;
      tick(8);
      check("retry wait", 24'({as_n, ds_n, gnt_n}), 24'h6);
      {br_n, mode, hold} = {1'b1, 3'h0, 1'b0};
      wait_done();
      check("rerun", 24'({cb, oaddr}), 24'h77);
      // second error while the exception is outstanding
      mode = 3'h1;
      run(1'b1, 1'b0, 24'h9);
      pulse_ie();
      run(1'b1, 1'b0, 24'ha);
      tick(2);
      check("dfault", 24'({df, hoe}), 24'h3);
      br_n = 1'b0;
      tick(4);
      check("df grant", 24'(gnt_n), 24'h0);
      end_sim();
   end
endmodule : bus_cycle_termination_ctrl_bench
`default_nettype wire
